// File: design/uorx_pkg.sv
// constants, field layouts and carriers of the usb receive-status and channel control slice
// Function
// R1 - receive status carries low four frame-number bits, device mode only
// R2 - packet status codes 1..7; codes 1,3,4,5,7 raise an interrupt
// R3 - data pid reported as two-bit code DATA0/DATA1/DATA2/MDATA
// R4 - eleven-bit byte count field in both host and device modes
// R5 - pop read returns head entry of receive fifo and removes it
// R6 - pop read on empty fifo returns zero, fifo unchanged
// R7 - software pops only while receive-fifo-nonempty flag is set
// R8 - port connect status reads one while a device is attached
// R9 - only the core sets port change flag; software writes one to clear
// R10 - software sets channel enable; core clears it when channel finishes
// R11 - channel disable stops the channel early; software waits for halt
// R12 - periodic channel runs in odd frame if odd bit set, else even
// R13 - multi count gives transactions per frame for periodic channels
// R14 - transmit fifo free space in words, sixteen bits, resets to 0x0200
// R15 - writing one to set-nak sets endpoint nak state
// R16 - core sets nak state on transfer complete and on setup received
// R17 - endpoint 0 is control type, its disable bit always reads zero
package uorx_pkg;
  // register byte addresses
  localparam logic [19:0] UORX_ADDR_RXPOP   = 20'h3C020;
  localparam logic [19:0] UORX_ADDR_HCCHAR  = 20'h3C500;
  localparam logic [19:0] UORX_ADDR_EP0CTL  = 20'h3CB00;
  localparam logic [19:0] UORX_ADDR_TXSPACE = 20'h3C530;
  localparam logic [19:0] UORX_ADDR_INTSTAT = 20'h3C014;
  localparam logic [19:0] UORX_ADDR_INTCLR  = 20'h3C018;
  localparam logic [19:0] UORX_ADDR_INTEN   = 20'h3C01C;
  localparam logic [19:0] UORX_ADDR_PORT    = 20'h3C440;
  // field positions
  localparam int UORX_HC_ENA    = 31;
  localparam int UORX_HC_DIS    = 30;
  localparam int UORX_HC_ODD    = 29;
  localparam int UORX_EP_ENA    = 31;
  localparam int UORX_EP_SET_NAK   = 27;
  localparam int UORX_EP_CLEAR_NAK   = 26;
  localparam int UORX_EP_STALL  = 21;
  localparam int UORX_EP_SNP    = 20;
  localparam int UORX_EP_NAKST  = 17;
  localparam int UORX_EP_ACTIVE = 15;
  localparam int UORX_PORT_CHG  = 1;
  // interrupt status bit positions
  localparam int UORX_IRQ_RXNE  = 0;
  localparam int UORX_IRQ_PKT   = 1;
  localparam int UORX_IRQ_PORT  = 2;
  localparam int UORX_IRQ_HALT  = 3;
  localparam int UORX_IRQ_W     = 4;
  // reset values and depths
  localparam logic [15:0] UORX_TXSPACE_RST = 16'h0200;
  localparam logic [31:0] UORX_ZERO32      = 32'h0000_0000;
  localparam int          UORX_FIFO_DEPTH  = 4;
  localparam int          UORX_PTR_W       = 2;
  // packet status codes
  typedef enum logic [3:0] {
    UORX_PS_GLOBAL_OUT_NAK_STATUS  = 4'h1,
    UORX_PS_RCV      = 4'h2,
    UORX_PS_XFERDONE = 4'h3,
    UORX_PS_SETUPDN  = 4'h4,
    UORX_PS_TOGGLE_ERROR_STATUS   = 4'h5,
    UORX_PS_SETUP_RECEIVED_STATUS = 4'h6,
    UORX_PS_CHHALT   = 4'h7
  } uorx_packet_status_t;
  // receive status word as carried from the protocol engine
  typedef struct packed {
    logic [6:0]  reserved;
    logic [3:0]  frame_number_low;
    logic [3:0]  packet_status;
    logic [1:0]  data_pid_code;
    logic [10:0] byte_count;
    logic [3:0]  channel_endpoint_number;
  } uorx_rxsts_t;
  // events from the protocol engine
  typedef struct packed {
    logic channel_done;
    logic channel_halted;
    logic ep0_xfer_done;
    logic ep0_setup_rcv;
  } uorx_evt_t;
endpackage : uorx_pkg

// File: design/uorx_top.sv
// receive-status pop, host channel control, endpoint 0 control and tx space report
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module uorx_top
  import uorx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [19:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // receive status push from the protocol engine
  input  wire logic        rx_push,
  input  uorx_rxsts_t      rx_word,
  output logic             rx_push_ready,
  input  wire logic        device_mode,
  // engine events and levels
  input  uorx_evt_t        evt,
  input  wire logic        port_attached_pin,
  input  wire logic [15:0] tx_space_words,
  input  wire logic        tx_space_load,
  // channel control towards the engine
  output logic             channel_run,
  output logic             channel_stop,
  output logic             channel_odd_frame,
  output logic [1:0]       channel_multi_count,
  output logic             ep0_nak,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge
  logic        ack_r;
  logic        wait_r;
  logic        req;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rdata_nxt;
  logic [31:0] avs_readdata_r;

  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & ~ack_r;
  assign rd_go = avs_read & ~ack_r;

  // ack_r marks the cycle in which waitrequest is low; the pin has its own
  // flop so no gate sits between a register and the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r  <= 1'b0;
      wait_r <= 1'b1;
    end else begin
      ack_r  <= req & ~ack_r;
      wait_r <= ~(req & ~ack_r);
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = avs_readdata_r;

  ////////////////////////////////////////////////////////////////////////
  // receive status fifo, flip-flop storage
  uorx_rxsts_t           fifo_mem_r [UORX_FIFO_DEPTH];
  logic [UORX_PTR_W-1:0] wr_ptr_r;
  logic [UORX_PTR_W-1:0] rd_ptr_r;
  logic [UORX_PTR_W:0]   count_r;
  logic                  fifo_empty;
  logic                  fifo_full;
  logic                  do_push;
  logic                  do_pop;
  logic [UORX_PTR_W:0]   count_nxt;
  logic                  ready_r;
  uorx_rxsts_t           push_word;

  assign fifo_empty = (count_r == '0);
  assign fifo_full  = (count_r == (UORX_PTR_W + 1)'(UORX_FIFO_DEPTH));
  assign do_push    = rx_push & ~fifo_full;
  // pop only on the first cycle of a read to the pop address, never on empty
  assign do_pop     = rd_go & (avs_address == UORX_ADDR_RXPOP) & ~fifo_empty; // R5 R6

  // frame number only meaningful in device mode, zero in host mode
  always_comb begin
    push_word = rx_word;
    push_word.reserved = '0;
    if (!device_mode) begin
      push_word.frame_number_low = '0; // R1
    end
  end

  // storage written at the tail
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      fifo_mem_r[wr_ptr_r] <= push_word; // R2 R3 R4
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1; // R5
      end
      count_r <= count_nxt;
    end
  end

  // fill level after this edge; push and pop in one cycle leave it unchanged
  always_comb begin
    count_nxt = count_r + (UORX_PTR_W + 1)'(do_push) - (UORX_PTR_W + 1)'(do_pop);
  end

  // ready is a flop loaded with the level the next edge will hold, so it
  // always equals not-full without a gate on the output
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= (count_nxt != (UORX_PTR_W + 1)'(UORX_FIFO_DEPTH));
    end
  end

  assign rx_push_ready = ready_r;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser for port attach
  logic attach_s1_r;
  logic attach_s2_r;
  logic attach_d_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      attach_s1_r <= 1'b0;
      attach_s2_r <= 1'b0;
      attach_d_r  <= 1'b0;
    end else begin
      attach_s1_r <= port_attached_pin;
      attach_s2_r <= attach_s1_r;
      attach_d_r  <= attach_s2_r;
    end
  end

  // port change flag: core sets on attach or detach edge, write one clears, set wins
  logic port_chg_r;
  logic port_wr;

  assign port_wr = wr_go & (avs_address == UORX_ADDR_PORT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_chg_r <= 1'b0;
    end else if (attach_s2_r != attach_d_r) begin
      port_chg_r <= 1'b1; // R9
    end else if (port_wr && avs_byteenable[0] && avs_writedata[UORX_PORT_CHG]) begin
      port_chg_r <= 1'b0; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host channel characteristics
  logic [31:0] hc_char_r;
  logic        hc_wr;

  assign hc_wr = wr_go & (avs_address == UORX_ADDR_HCCHAR);

  // enable set by software, cleared by the core when done or halted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hc_char_r <= UORX_ZERO32;
    end else begin
      if (hc_wr) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            hc_char_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          end
        end
        // enable and disable only set by a written one
        hc_char_r[UORX_HC_ENA] <= hc_char_r[UORX_HC_ENA] |
                                  (avs_byteenable[3] & avs_writedata[UORX_HC_ENA]); // R10
        hc_char_r[UORX_HC_DIS] <= hc_char_r[UORX_HC_DIS] |
                                  (avs_byteenable[3] & avs_writedata[UORX_HC_DIS]); // R11
      end
      hc_char_r[16] <= 1'b0;
      // the halt from the engine clears both; it ends an aborted transfer too
      if (evt.channel_done || evt.channel_halted) begin
        hc_char_r[UORX_HC_ENA] <= 1'b0; // R10
        hc_char_r[UORX_HC_DIS] <= 1'b0; // R11
      end
    end
  end

  // engine controls come from flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channel_run         <= 1'b0;
      channel_stop        <= 1'b0;
      channel_odd_frame   <= 1'b0;
      channel_multi_count <= 2'h0;
    end else begin
      channel_run         <= hc_char_r[UORX_HC_ENA] & ~hc_char_r[UORX_HC_DIS]; // R10
      channel_stop        <= hc_char_r[UORX_HC_DIS]; // R11
      channel_odd_frame   <= hc_char_r[UORX_HC_ODD]; // R12
      channel_multi_count <= hc_char_r[21:20]; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // endpoint 0 out control
  logic ep0_ena_r;
  logic ep0_stall_r;
  logic ep0_snoop_r;
  logic ep0_nak_r;
  logic ep_wr;

  assign ep_wr = wr_go & (avs_address == UORX_ADDR_EP0CTL);

  // enable: software sets, core clears on completion or setup
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ep0_ena_r   <= 1'b0;
      ep0_stall_r <= 1'b0;
      ep0_snoop_r <= 1'b0;
    end else begin
      if (ep_wr && avs_byteenable[3] && avs_writedata[UORX_EP_ENA]) begin
        ep0_ena_r <= 1'b1;
      end else if (evt.ep0_xfer_done || evt.ep0_setup_rcv) begin
        ep0_ena_r <= 1'b0;
      end
      if (ep_wr && avs_byteenable[2]) begin
        ep0_snoop_r <= avs_writedata[UORX_EP_SNP];
        if (avs_writedata[UORX_EP_STALL]) begin
          ep0_stall_r <= 1'b1;
        end
      end
      if (evt.ep0_setup_rcv) begin
        ep0_stall_r <= 1'b0;
      end
    end
  end

  // nak state: core events and set-nak win over clear-nak
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ep0_nak_r <= 1'b0;
    end else if (evt.ep0_xfer_done || evt.ep0_setup_rcv) begin
      ep0_nak_r <= 1'b1; // R16
    end else if (ep_wr && avs_byteenable[3] && avs_writedata[UORX_EP_SET_NAK]) begin
      ep0_nak_r <= 1'b1; // R15
    end else if (ep_wr && avs_byteenable[3] && avs_writedata[UORX_EP_CLEAR_NAK]) begin
      ep0_nak_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ep0_nak <= 1'b0;
    end else begin
      ep0_nak <= ep0_nak_r | ep0_stall_r; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit fifo space report
  logic [15:0] tx_space_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_space_r <= UORX_TXSPACE_RST; // R14
    end else if (tx_space_load) begin
      tx_space_r <= tx_space_words; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status except the live nonempty bit, write-one clear, enable mask
  logic [UORX_IRQ_W-1:0] int_stat_r;
  logic [UORX_IRQ_W-1:0] int_en_r;
  logic [UORX_IRQ_W-1:0] int_set;
  logic [UORX_IRQ_W-1:0] int_clr;
  logic                  pkt_irq;
  uorx_packet_status_t          push_sts;

  assign push_sts = uorx_packet_status_t'(push_word.packet_status);
  // status codes that raise an interrupt
  always_comb begin
    case (push_sts)
      UORX_PS_GLOBAL_OUT_NAK_STATUS, UORX_PS_XFERDONE, UORX_PS_SETUPDN,
      UORX_PS_TOGGLE_ERROR_STATUS, UORX_PS_CHHALT: pkt_irq = do_push; // R2
      default:                        pkt_irq = 1'b0;
    endcase
  end

  always_comb begin
    int_set                = '0;
    int_set[UORX_IRQ_PKT]  = pkt_irq;
    int_set[UORX_IRQ_PORT] = attach_s2_r != attach_d_r; // R9
    int_set[UORX_IRQ_HALT] = evt.channel_halted;
  end

  assign int_clr = (wr_go && avs_address == UORX_ADDR_INTCLR && avs_byteenable[0]) ?
                   avs_writedata[UORX_IRQ_W-1:0] : '0;

  // set wins over clear; the nonempty bit is a live level, not sticky
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      int_stat_r[UORX_IRQ_RXNE] <= ~fifo_empty; // R7
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_en_r <= '0;
    end else if (wr_go && avs_address == UORX_ADDR_INTEN && avs_byteenable[0]) begin
      int_en_r <= avs_writedata[UORX_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_r & int_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered into the answer cycle
  always_comb begin
    rdata_nxt = UORX_ZERO32;
    case (avs_address)
      UORX_ADDR_RXPOP: begin
        if (!fifo_empty) begin
          rdata_nxt = fifo_mem_r[rd_ptr_r]; // R5
        end
      end
      UORX_ADDR_HCCHAR:  rdata_nxt = hc_char_r; // R10
      UORX_ADDR_EP0CTL: begin
        rdata_nxt[UORX_EP_ENA]    = ep0_ena_r;
        rdata_nxt[UORX_EP_STALL]  = ep0_stall_r;
        rdata_nxt[UORX_EP_SNP]    = ep0_snoop_r;
        rdata_nxt[UORX_EP_NAKST]  = ep0_nak_r; // R15
        rdata_nxt[UORX_EP_ACTIVE] = 1'b1;
        // disable bit, type field and max packet size read zero
        rdata_nxt[19:18]          = 2'h0; // R17
      end
      UORX_ADDR_TXSPACE: rdata_nxt[15:0] = tx_space_r; // R14
      UORX_ADDR_INTSTAT: rdata_nxt[UORX_IRQ_W-1:0] = int_stat_r;
      UORX_ADDR_INTEN:   rdata_nxt[UORX_IRQ_W-1:0] = int_en_r;
      UORX_ADDR_PORT: begin
        rdata_nxt[UORX_PORT_CHG] = port_chg_r;
        rdata_nxt[0]             = attach_s2_r; // R8
      end
      default:           rdata_nxt = UORX_ZERO32;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata_r <= UORX_ZERO32;
    end else if (rd_go) begin
      avs_readdata_r <= rdata_nxt;
    end
  end

endmodule // uorx_top

// File: bench/uorx_top_sva.sv
// concurrent checks on the ports of the receive-status and channel control slice
`timescale 1ns/1ps
module uorx_top_sva
  import uorx_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [19:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input uorx_evt_t        evt,
  input wire logic        channel_run,
  input wire logic        channel_stop,
  input wire logic        channel_odd_frame,
  input wire logic        ep0_nak
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answers one cycle after the request is taken, for one cycle only
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered in one cycle");
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer stood longer than one cycle");
  // engine completion clears the register, then the port flop one edge later
  property p_run_clr; evt.channel_done |-> ##2 !channel_run; endproperty
  a_run_clr: assert property (p_run_clr) else $error("channel still running after done");
  property p_stop_clr; evt.channel_halted |-> ##2 !channel_stop && !channel_run; endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("channel not cleared on halt");
  // channel bits only rise from a software write one or two cycles before
  property p_run_src; $rose(channel_run) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_run_src: assert property (p_run_src) else $error("channel started without a write");
  property p_stop_src;
    $rose(channel_stop) |-> $past(avs_write && avs_writedata[30]) ||
                            $past(avs_write && avs_writedata[30], 2);
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("channel stop without a write");
  property p_odd_src;
    $changed(channel_odd_frame) |-> $past(avs_write && avs_address == UORX_ADDR_HCCHAR) ||
                                    $past(avs_write && avs_address == UORX_ADDR_HCCHAR, 2);
  endproperty
  a_odd_src: assert property (p_odd_src) else $error("odd frame moved without a write");
  // endpoint nak is forced by engine events, otherwise only by a write
  property p_nak_evt; evt.ep0_xfer_done || evt.ep0_setup_rcv |-> ##2 ep0_nak; endproperty
  a_nak_evt: assert property (p_nak_evt) else $error("nak not set by endpoint event");
  property p_nak_src;
    $rose(ep0_nak) |-> $past(evt.ep0_xfer_done || evt.ep0_setup_rcv, 2) ||
                       $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_nak_src: assert property (p_nak_src) else $error("nak set without a cause");
  c_run: cover property ($fell(channel_run));
  c_stop: cover property ($rose(channel_stop));
  c_nak: cover property ($rose(ep0_nak));
endmodule // uorx_top_sva

// File: bench/uorx_engine_model.sv
// behavioural protocol engine: pushes status words, pulses events, drives levels
`timescale 1ns/1ps
module uorx_engine_model
  import uorx_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             rx_push,
  output uorx_rxsts_t      rx_word,
  output logic             device_mode,
  output uorx_evt_t        evt,
  output logic             port_attached_pin,
  output logic [15:0]      tx_space_words,
  output logic             tx_space_load
);
  // idle data is inverted so a stale word is never mistaken for a fresh one
  initial begin
    rx_push = 1'b0;
    rx_word = '0;
    device_mode = 1'b1;
    evt = '0;
    port_attached_pin = 1'b0;
    tx_space_words = 16'h0000;
    tx_space_load = 1'b0;
  end
  task automatic push(input uorx_rxsts_t w, input logic dm);
    @(posedge clk_sys);
    rx_push <= 1'b1;
    rx_word <= w;
    device_mode <= dm;
    @(posedge clk_sys);
    rx_push <= 1'b0;
    rx_word <= ~w;
  endtask
  task automatic pulse(input uorx_evt_t e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
  endtask
  task automatic attach(input logic v);
    @(posedge clk_sys);
    port_attached_pin <= v;
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge clk_sys);
    tx_space_words <= v;
    tx_space_load <= 1'b1;
    @(posedge clk_sys);
    tx_space_words <= ~v;
    tx_space_load <= 1'b0;
  endtask
endmodule // uorx_engine_model

// File: bench/tb.sv
// self-checking bench for the receive-status and channel control slice
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import uorx_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [19:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, rx_push, rx_push_ready, device_mode, port_attached_pin;
  logic        tx_space_load, channel_run, channel_stop, channel_odd_frame, ep0_nak, irq;
  logic [1:0]  channel_multi_count;
  logic [15:0] tx_space_words;
  uorx_rxsts_t rx_word, w;
  uorx_evt_t   evt;
  logic        exp_irq;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  uorx_top dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_push, .rx_word,
    .rx_push_ready, .device_mode, .evt, .port_attached_pin, .tx_space_words,
    .tx_space_load, .channel_run, .channel_stop, .channel_odd_frame,
    .channel_multi_count, .ep0_nak, .irq);
  uorx_engine_model eng (.clk_sys, .rx_push, .rx_word, .device_mode, .evt,
    .port_attached_pin, .tx_space_words, .tx_space_load);
  ////////////////////////////////////////////////////////////////////////////////
  // one avalon access; the request stands until waitrequest is seen low
  task automatic acc(input logic o, input logic [19:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= o;
    avs_read <= !o;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdm(input logic [19:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdm(UORX_ADDR_TXSPACE, '1, {16'h0000, UORX_TXSPACE_RST});
    rdm(UORX_ADDR_EP0CTL, '1, 32'h0000_8000);
    rdm(20'h3C100, '1, UORX_ZERO32);
    rdm(UORX_ADDR_RXPOP, '1, UORX_ZERO32);
    wr(UORX_ADDR_INTEN, 32'h0000_000E);
    // each status code 1..7 with one pid, all four pids covered, popped while the flag says non-empty
    for (int i = 1; i < 8; i++) begin
      w = '{7'h00, 4'hA, 4'(i), 2'(i), 11'h7F0 + 11'(i), 4'(i)};
      eng.push(w, 1'b1);
      exp_irq = (i != 2 && i != 6);
      rdm(UORX_ADDR_INTSTAT, 32'h3, {30'h0, exp_irq, 1'b1});
      `CHK(irq, exp_irq)
      rdm(UORX_ADDR_RXPOP, '1, 32'(w));
      wr(UORX_ADDR_INTCLR, 32'h0000_0002);
    end
    rdm(UORX_ADDR_RXPOP, '1, UORX_ZERO32);
    rdm(UORX_ADDR_INTSTAT, 32'h1, 32'h0);
    `CHK(irq, 1'b0)
    // host mode drops the frame number but keeps the byte count
    w = '{7'h00, 4'hF, 4'h2, 2'h1, 11'h005, 4'h3};
    eng.push(w, 1'b0);
    w.frame_number_low = 4'h0;
    rdm(UORX_ADDR_RXPOP, '1, 32'(w));
    // four entries fill the fifo; ready falls and returns once they are popped in order
    for (int k = 0; k < 4; k++) begin
      w.byte_count = 11'(k);
      eng.push(w, 1'b0);
    end
    @(negedge clk_sys);
    `CHK(rx_push_ready, 1'b0)
    for (int k = 0; k < 4; k++) begin
      w.byte_count = 11'(k);
      rdm(UORX_ADDR_RXPOP, '1, 32'(w));
    end
    `CHK(rx_push_ready, 1'b1)
    // attach raises connect and the change flag, which only a one clears
    eng.attach(1'b1);
    repeat (4) @(posedge clk_sys);
    rdm(UORX_ADDR_PORT, 32'h3, 32'h3);
    `CHK(irq, 1'b1)
    wr(UORX_ADDR_PORT, 32'h0000_0001);
    rdm(UORX_ADDR_PORT, 32'h3, 32'h3);
    wr(UORX_ADDR_PORT, 32'h0000_0002);
    rdm(UORX_ADDR_PORT, 32'h3, 32'h1);
    wr(UORX_ADDR_INTCLR, 32'h0000_0004);
    // low three bytes only: multi count lands, enable and disable stay clear
    avs_byteenable <= 4'h7;
    wr(UORX_ADDR_HCCHAR, 32'hFFFF_FFFF);
    avs_byteenable <= 4'hF;
    @(negedge clk_sys);
    `CHK({channel_run, channel_multi_count}, 3'b011)
    rdm(UORX_ADDR_HCCHAR, 32'hE030_0000, 32'h0030_0000);
    // channel enable, odd frame and multi count, then engine completion
    wr(UORX_ADDR_HCCHAR, 32'hA020_0000);
    @(negedge clk_sys);
    `CHK({channel_run, channel_odd_frame, channel_multi_count}, 4'b1110)
    rdm(UORX_ADDR_HCCHAR, 32'hE030_0000, 32'hA020_0000);
    eng.pulse('{1'b1, 1'b0, 1'b0, 1'b0});
    // the event clears the register, the port flop follows one edge later
    repeat (2) @(negedge clk_sys);
    `CHK(channel_run, 1'b0)
    rdm(UORX_ADDR_HCCHAR, 32'h8000_0000, 32'h0);
    wr(UORX_ADDR_HCCHAR, 32'hC000_0000);
    @(negedge clk_sys);
    `CHK({channel_run, channel_stop, channel_odd_frame}, 3'b010)
    eng.pulse('{1'b0, 1'b1, 1'b0, 1'b0});
    repeat (2) @(negedge clk_sys);
    `CHK({channel_run, channel_stop}, 2'b00)
    rdm(UORX_ADDR_INTSTAT, 32'h8, 32'h8);
    // endpoint nak: set by write, then forced back by each core event
    wr(UORX_ADDR_EP0CTL, 32'h480C_0000);
    @(negedge clk_sys);
    `CHK(ep0_nak, 1'b1)
    rdm(UORX_ADDR_EP0CTL, 32'h400E_8000, 32'h0002_8000);
    for (int j = 0; j < 2; j++) begin
      wr(UORX_ADDR_EP0CTL, 32'h0400_0000);
      @(negedge clk_sys);
      `CHK(ep0_nak, 1'b0)
      eng.pulse('{1'b0, 1'b0, j == 0, j == 1});
      repeat (2) @(negedge clk_sys);
      `CHK(ep0_nak, 1'b1)
    end
    eng.load(16'h0123);
    rdm(UORX_ADDR_TXSPACE, '1, 32'h0000_0123);
    report_and_stop();
  end
endmodule // tb
bind uorx_top uorx_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .evt(evt),
  .channel_run(channel_run), .channel_stop(channel_stop),
  .channel_odd_frame(channel_odd_frame), .ep0_nak(ep0_nak));
